//--- rtl/arrs_top.sv
// module: apb slave, conversion sequencer and result encoding of the converter
module arrs_top
  import arrs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] ain_pos_code,
  input wire logic [9:0] ain_neg_code,
  output logic irq,
  output arrs_ana_t ana
);
  logic [7:0] irs_r, irs_nxt, ctrl_r, ctrl_nxt, ctrlb_r, ctrlb_nxt;
  logic [7:0] mask_r, mask_nxt, istat_r, istat_nxt, app_r, app_nxt;
  logic [9:0] result_r, result_nxt;
  arrs_state_t state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic first_r, first_nxt, refchg_r, refchg_nxt;
  arrs_ana_t ana_r, ana_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
  logic [9:0] pos_m, pos_s, neg_m, neg_s;
  logic [5:0] idx;
  logic wr_acc, rd_setup, en, bip, diff_mode, done_evt;
  logic signed [10:0] diff;
  logic signed [15:0] prod, half;
  logic [9:0] conv_val;

  // two-stage synchronisers for the front-end codes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_m <= ARRS_CODE_ZERO;
      pos_s <= ARRS_CODE_ZERO;
      neg_m <= ARRS_CODE_ZERO;
      neg_s <= ARRS_CODE_ZERO;
    end else begin
      pos_m <= ain_pos_code;
      pos_s <= pos_m;
      neg_m <= ain_neg_code;
      neg_s <= neg_m;
    end
  end

  assign idx = paddr[7:2];
  assign wr_acc = psel & penable & pready_r & pwrite;
  assign rd_setup = psel & ~penable;
  assign en = ctrl_r[ARRS_CTRL_EN_BIT];
  assign bip = ctrlb_r[ARRS_CTRLB_BIP_BIT];
  assign done_evt = (state_r == ARRS_ST_CONV) && (cnt_r == 5'h00) && en;

  // result encoding from applied channel settings
  always_comb begin
    diff_mode = ((app_r[5:0] >= ARRS_MUX_DIFF_LO) && (app_r[5:0] <= ARRS_MUX_DIFF_HI))
      || (app_r[5:0] >= ARRS_MUX_CAL_LO);
    diff = $signed({1'b0, pos_s}) - $signed({1'b0, neg_s});
    prod = 16'(diff) * (app_r[0] ? ARRS_GAIN_HIGH : ARRS_GAIN_UNIT);
    half = prod >>> 1;
    if (!diff_mode) begin
      conv_val = pos_s;
    end else if (!bip) begin
      if (prod < 0) begin
        conv_val = ARRS_CODE_ZERO;
      end else if (prod > ARRS_UNI_MAX) begin
        conv_val = ARRS_CODE_UNI_MAX;
      end else begin
        conv_val = prod[9:0];
      end
    end else begin
      if (half < ARRS_BIP_MIN) begin
        conv_val = ARRS_CODE_BIP_MIN;
      end else if (half > ARRS_BIP_MAX) begin
        conv_val = ARRS_CODE_BIP_MAX;
      end else begin
        conv_val = half[9:0];
      end
    end
  end

  always_comb begin
    irs_nxt = irs_r;
    ctrl_nxt = ctrl_r;
    ctrlb_nxt = ctrlb_r;
    mask_nxt = mask_r;
    istat_nxt = istat_r;
    app_nxt = app_r;
    result_nxt = result_r;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    first_nxt = first_r;
    refchg_nxt = refchg_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt = psel & penable & ~pready_r;
    if (rd_setup) begin
      pslverr_nxt = 1'b0;
      case (idx)
        ARRS_IDX_CTRLB: prdata_nxt = {24'h00_0000, ctrlb_r};
        ARRS_IDX_RESL: prdata_nxt = {24'h00_0000, result_r[7:0]};
        ARRS_IDX_RESH: prdata_nxt = {30'h0000_0000, result_r[9:8]};
        ARRS_IDX_CTRL: prdata_nxt = {24'h00_0000, ctrl_r};
        ARRS_IDX_IRS: prdata_nxt = {24'h00_0000, irs_r};
        ARRS_IDX_ISTAT: prdata_nxt = {24'h00_0000, istat_r};
        ARRS_IDX_MASK: prdata_nxt = {24'h00_0000, mask_r};
        default: begin
          prdata_nxt = 32'h0000_0000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    if (wr_acc) begin
      case (idx)
        ARRS_IDX_CTRLB: ctrlb_nxt = pwdata[7:0] & 8'h80;
        ARRS_IDX_CTRL: ctrl_nxt = pwdata[7:0] & 8'hc0;
        ARRS_IDX_IRS: irs_nxt = pwdata[7:0];
        ARRS_IDX_ISTAT: istat_nxt = istat_r & ~pwdata[7:0];
        ARRS_IDX_MASK: mask_nxt = pwdata[7:0] & 8'h01;
        default: ;
      endcase
      // start stays set while busy
      if (state_r == ARRS_ST_CONV && idx == ARRS_IDX_CTRL) begin
        ctrl_nxt[ARRS_CTRL_START_BIT] = 1'b1;
      end
    end
    if (!en && ctrl_nxt[ARRS_CTRL_EN_BIT]) begin
      first_nxt = 1'b1;
    end
    case (state_r)
      ARRS_ST_IDLE: begin
        app_nxt = irs_r;
        if (irs_r[ARRS_REF_MSB:ARRS_REF_LSB] != app_r[ARRS_REF_MSB:ARRS_REF_LSB]) begin
          refchg_nxt = 1'b1;
        end
        if (ctrl_r[ARRS_CTRL_START_BIT] && !en) begin
          ctrl_nxt[ARRS_CTRL_START_BIT] = 1'b0;
        end else if (ctrl_r[ARRS_CTRL_START_BIT]) begin
          state_nxt = ARRS_ST_CONV;
          cnt_nxt = (first_r || refchg_r) ? ARRS_CONV_LONG - 5'h01
            : ARRS_CONV_NORMAL - 5'h01;
          first_nxt = 1'b0;
          refchg_nxt = 1'b0;
        end
      end
      ARRS_ST_CONV: begin
        if (!en) begin
          state_nxt = ARRS_ST_IDLE;
          ctrl_nxt[ARRS_CTRL_START_BIT] = 1'b0;
        end else if (cnt_r == 5'h00) begin
          state_nxt = ARRS_ST_IDLE;
          result_nxt = conv_val;
          istat_nxt[ARRS_INT_DONE_BIT] = 1'b1;
          ctrl_nxt[ARRS_CTRL_START_BIT] = 1'b0;
        end else begin
          cnt_nxt = cnt_r - 5'h01;
        end
      end
      default: state_nxt = ARRS_ST_IDLE;
    endcase
    irq_nxt = |(istat_nxt & mask_nxt);
    ana_nxt.ref_supply = app_nxt[ARRS_REF_MSB:ARRS_REF_LSB] == ARRS_REF_SUPPLY;
    ana_nxt.ref_external = app_nxt[ARRS_REF_MSB:ARRS_REF_LSB] == ARRS_REF_EXT;
    ana_nxt.ref_internal = app_nxt[ARRS_REF_MSB:ARRS_REF_LSB] == ARRS_REF_INT;
    ana_nxt.temp_en = app_nxt[5:0] == ARRS_MUX_TEMP;
    ana_nxt.gain_20x = app_nxt[0];
    ana_nxt.mux = app_nxt[5:0];
    ana_nxt.converting = state_nxt == ARRS_ST_CONV;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irs_r <= ARRS_IRS_RST;
      ctrl_r <= ARRS_CTRL_RST;
      ctrlb_r <= ARRS_CTRLB_RST;
      mask_r <= ARRS_INT_RST;
      istat_r <= ARRS_INT_RST;
      app_r <= ARRS_IRS_RST;
      result_r <= ARRS_RES_RST;
      state_r <= ARRS_ST_IDLE;
      cnt_r <= 5'h00;
      first_r <= 1'b0;
      refchg_r <= 1'b0;
      ana_r <= '0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      irs_r <= irs_nxt;
      ctrl_r <= ctrl_nxt;
      ctrlb_r <= ctrlb_nxt;
      mask_r <= mask_nxt;
      istat_r <= istat_nxt;
      app_r <= app_nxt;
      result_r <= result_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      first_r <= first_nxt;
      refchg_r <= refchg_nxt;
      ana_r <= ana_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign ana = ana_r;

  property p_conv_len;
    @(posedge clk) disable iff (rst)
    (state_r == ARRS_ST_CONV && $past(state_r) == ARRS_ST_IDLE)
      |-> cnt_r == (($past(first_r) || $past(refchg_r)) ? ARRS_CONV_LONG - 5'h01
        : ARRS_CONV_NORMAL - 5'h01);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("wrong conversion length");

  property p_ref_change_long;
    @(posedge clk) disable iff (rst)
    (state_r == ARRS_ST_IDLE && refchg_r && ctrl_r[ARRS_CTRL_START_BIT] && en)
      |=> cnt_r == ARRS_CONV_LONG - 5'h01;
  endproperty
  a_ref_change_long: assert property (p_ref_change_long) else $error("no long conversion");

  property p_settings_held;
    @(posedge clk) disable iff (rst)
    (state_r == ARRS_ST_CONV) ##1 (state_r == ARRS_ST_CONV) |-> $stable(app_r);
  endproperty
  a_settings_held: assert property (p_settings_held) else $error("settings changed midway");

  property p_done_sets_flag;
    @(posedge clk) disable iff (rst)
    done_evt |=> istat_r[0] && state_r == ARRS_ST_IDLE && result_r == $past(conv_val);
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag) else $error("done flag not set");

  property p_single_ended;
    @(posedge clk) disable iff (rst)
    (done_evt && !diff_mode) |=> result_r == $past(pos_s);
  endproperty
  a_single_ended: assert property (p_single_ended) else $error("single-ended code wrong");

  property p_unipolar_clamp;
    @(posedge clk) disable iff (rst)
    (done_evt && diff_mode && !bip && pos_s < neg_s) |=> result_r == 10'h000;
  endproperty
  a_unipolar_clamp: assert property (p_unipolar_clamp) else $error("unipolar not clamped");

  property p_bipolar_sign;
    @(posedge clk) disable iff (rst)
    (done_evt && diff_mode && bip) |=> result_r[9] == ($past(pos_s) < $past(neg_s));
  endproperty
  a_bipolar_sign: assert property (p_bipolar_sign) else $error("bipolar sign wrong");

  property p_temp_enable;
    @(posedge clk) disable iff (rst)
    ana_r.temp_en == (app_r[5:0] == ARRS_MUX_TEMP);
  endproperty
  a_temp_enable: assert property (p_temp_enable) else $error("temperature enable wrong");

  property p_ref_decode;
    @(posedge clk) disable iff (rst)
    ana_r.ref_internal == (app_r[7:6] == 2'h2) && ana_r.ref_external == (app_r[7:6] == 2'h1);
  endproperty
  a_ref_decode: assert property (p_ref_decode) else $error("reference decode wrong");

  property p_gain_bit;
    @(posedge clk) disable iff (rst)
    ana_r.gain_20x == app_r[0];
  endproperty
  a_gain_bit: assert property (p_gain_bit) else $error("gain select wrong");

  property p_apb_wait;
    @(posedge clk) disable iff (rst)
    (psel && !penable) ##1 (psel && penable) |=> pready_r;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");

  // first start after enable runs the long conversion
  property p_first_long;
    @(posedge clk) disable iff (rst)
    (state_r == ARRS_ST_IDLE && first_r && ctrl_r[ARRS_CTRL_START_BIT] && en)
      |=> state_r == ARRS_ST_CONV && cnt_r == ARRS_CONV_LONG - 5'h01;
  endproperty
  a_first_long: assert property (p_first_long) else $error("first conversion not long");

  // front-end selection outputs frozen while converting
  property p_ref_outputs_held;
    @(posedge clk) disable iff (rst)
    (state_r == ARRS_ST_CONV) |=> $stable(ana_r.mux) && $stable(ana_r.ref_internal)
      && $stable(ana_r.ref_external) && $stable(ana_r.ref_supply);
  endproperty
  a_ref_outputs_held: assert property (p_ref_outputs_held) else $error("selection moved");

  property p_irq_level;
    @(posedge clk) disable iff (rst)
    irq_r == |(istat_r & mask_r);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule

//--- rtl/arrs_pkg.sv
// package: register map, fields, timing and types of the converter result block
// Summary of operation
// - result readable once done flag is set
// - single-ended result is unsigned input code
// - unipolar differential clamps negative difference to zero
// - differential gain is only 1x or 20x
// - bipolar result two's complement, 512 scale, clamped
// - bipolar sign sits in top result bit
// - unipolar by default, bipolar when select set
// - temperature sensor enabled for field 100010
// - reference field decodes supply, external, internal, reserved
// - reference write deferred until running conversion ends
// - reference change makes next conversion 25 cycles
// - channel field write deferred until conversion ends
// - first conversion after enable or after reference change 25, else 13
// - lowest channel bit selects 1x or 20x
package arrs_pkg;
  // register indexes; byte address is index times four
  localparam logic [5:0] ARRS_IDX_CTRLB = 6'h03;
  localparam logic [5:0] ARRS_IDX_RESL = 6'h04;
  localparam logic [5:0] ARRS_IDX_RESH = 6'h05;
  localparam logic [5:0] ARRS_IDX_CTRL = 6'h06;
  localparam logic [5:0] ARRS_IDX_IRS = 6'h07;
  localparam logic [5:0] ARRS_IDX_ISTAT = 6'h08;
  localparam logic [5:0] ARRS_IDX_MASK = 6'h09;
  localparam int ARRS_CTRL_EN_BIT = 7;
  localparam int ARRS_CTRL_START_BIT = 6;
  localparam int ARRS_CTRLB_BIP_BIT = 7;
  localparam int ARRS_INT_DONE_BIT = 0;
  localparam int ARRS_REF_MSB = 7;
  localparam int ARRS_REF_LSB = 6;
  localparam logic [7:0] ARRS_IRS_RST = 8'h00;
  localparam logic [7:0] ARRS_CTRL_RST = 8'h00;
  localparam logic [7:0] ARRS_CTRLB_RST = 8'h00;
  localparam logic [7:0] ARRS_INT_RST = 8'h00;
  localparam logic [9:0] ARRS_RES_RST = 10'h000;
  localparam logic [4:0] ARRS_CONV_NORMAL = 5'h0d;
  localparam logic [4:0] ARRS_CONV_LONG = 5'h19;
  localparam logic [1:0] ARRS_REF_SUPPLY = 2'h0;
  localparam logic [1:0] ARRS_REF_EXT = 2'h1;
  localparam logic [1:0] ARRS_REF_INT = 2'h2;
  localparam logic [5:0] ARRS_MUX_TEMP = 6'h22;
  localparam logic [5:0] ARRS_MUX_DIFF_LO = 6'h08;
  localparam logic [5:0] ARRS_MUX_DIFF_HI = 6'h1f;
  localparam logic [5:0] ARRS_MUX_CAL_LO = 6'h23;
  localparam logic signed [15:0] ARRS_GAIN_HIGH = 16'sh0014;
  localparam logic signed [15:0] ARRS_GAIN_UNIT = 16'sh0001;
  localparam logic signed [15:0] ARRS_UNI_MAX = 16'sh03ff;
  localparam logic signed [15:0] ARRS_BIP_MAX = 16'sh01ff;
  localparam logic signed [15:0] ARRS_BIP_MIN = 16'shfe00;
  localparam logic [9:0] ARRS_CODE_ZERO = 10'h000;
  localparam logic [9:0] ARRS_CODE_UNI_MAX = 10'h3ff;
  localparam logic [9:0] ARRS_CODE_BIP_MAX = 10'h1ff;
  localparam logic [9:0] ARRS_CODE_BIP_MIN = 10'h200;

  typedef enum logic [1:0] {
    ARRS_ST_IDLE = 2'b01,
    ARRS_ST_CONV = 2'b10
  } arrs_state_t;

  // controls toward the analog front end
  typedef struct packed {
    logic ref_supply;
    logic ref_external;
    logic ref_internal;
    logic temp_en;
    logic gain_20x;
    logic [5:0] mux;
    logic converting;
  } arrs_ana_t;
endpackage

//--- tb/arrs_analog_model.sv
// analog front end model: input codes held steady, updated on the clock
module arrs_analog_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] pos_req,
  input wire logic [9:0] neg_req,
  output logic [9:0] ain_pos_code,
  output logic [9:0] ain_neg_code
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ain_pos_code <= 10'h000;
      ain_neg_code <= 10'h000;
    end else begin
      ain_pos_code <= pos_req;
      ain_neg_code <= neg_req;
    end
  end
endmodule

//--- tb/adc_result_and_reference_select_tb_top.sv
// testbench: apb traffic, conversions, result encodings and reference handling
module adc_result_and_reference_select_tb_top
  import arrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, rerr, bip;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [9:0] pos_req, neg_req, ain_pos_code, ain_neg_code, e;
  logic [5:0] mux;
  logic [15:0] r;
  arrs_ana_t ana;
  int errors = 0, compares = 0, cyc = 0, run = 0, last_len = 0;
  logic [5:0] mt [8] = '{6'h08, 6'h09, 6'h1e, 6'h1f, 6'h23, 6'h29, 6'h20, 6'h22};
  logic [5:0] cm [3] = '{6'h09, 6'h09, 6'h08};
  logic [9:0] cp [3] = '{10'h3ff, 10'h000, 10'h100};
  logic [9:0] cn [3] = '{10'h000, 10'h3ff, 10'h200};
  logic cb [3] = '{1'b0, 1'b1, 1'b0};

  arrs_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ain_pos_code(ain_pos_code), .ain_neg_code(ain_neg_code), .irq(irq), .ana(ana));
  arrs_analog_model u_ana (.clk(clk), .rst(rst), .pos_req(pos_req), .neg_req(neg_req),
    .ain_pos_code(ain_pos_code), .ain_neg_code(ain_neg_code));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [9:0] exp_res(logic [5:0] m, logic b, logic [9:0] p, logic [9:0] n);
    int d;
    if (m < 6'h08 || (m >= 6'h20 && m < 6'h23)) return p;
    d = (int'(p) - int'(n)) * (m[0] ? 20 : 1);
    if (b) begin
      d = d >>> 1;
      d = (d > 511) ? 511 : ((d < -512) ? -512 : d);
    end else begin
      d = (d > 1023) ? 1023 : ((d < 0) ? 0 : d);
    end
    return d[9:0];
  endfunction

  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic chkb(input logic g, input logic x);
    compares++;
    if (g !== x) begin
      errors++;
      $display("ERROR t=%0t flag got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // waits out a conversion and checks its length in cycles
  task automatic finish(input int n);
    int k;
    k = 0;
    while (ana.converting !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    while (ana.converting === 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    if (k >= 40) errors++;
    chk(last_len, n);
  endtask

  always @(posedge clk) begin
    if (ana.converting === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pos_req, neg_req} = '0;
    r = 16'h005f;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      apb(0, ARRS_IDX_CTRLB + 6'(i), 8'h00);
      chk(rdata, 32'h0000_0000);
      chkb(rerr, 1'b0);
    end
    apb(0, 6'h3f, 8'h00);
    chk(rdata, 32'h0000_0000);
    chkb(rerr, 1'b1);
    apb(1, ARRS_IDX_MASK, 8'h01);
    pos_req <= 10'h2a5;
    apb(1, ARRS_IDX_IRS, 8'h03);
    apb(1, ARRS_IDX_CTRL, 8'hc0);
    finish(25);
    chkb(irq, 1'b1);
    apb(0, ARRS_IDX_RESL, 8'h00);
    chk(rdata, 32'h0000_00a5);
    apb(0, ARRS_IDX_RESH, 8'h00);
    chk(rdata, 32'h0000_0002);
    apb(1, ARRS_IDX_ISTAT, 8'h01);
    chkb(irq, 1'b0);
    apb(1, ARRS_IDX_MASK, 8'h00);
    for (int c = 0; c < 4; c++) begin
      apb(1, ARRS_IDX_IRS, {2'(c), 6'h00});
      @(posedge clk);
      chk({ana.ref_supply, ana.ref_external, ana.ref_internal},
        (c == 3) ? 0 : 4 >> c);
    end
    apb(1, ARRS_IDX_IRS, 8'h00);
    // off, then on again: long conversion
    apb(1, ARRS_IDX_CTRL, 8'h00);
    apb(1, ARRS_IDX_CTRL, 8'hc0);
    finish(25);
    // single-ended 13-cycle conversion, temperature channel and internal reference written mid conversion, then the 25-cycle one it causes
    apb(1, ARRS_IDX_CTRL, 8'hc0);
    apb(1, ARRS_IDX_IRS, 8'ha2);
    chkb(ana.ref_internal, 1'b0);
    chkb(ana.temp_en, 1'b0);
    finish(13);
    @(posedge clk);
    chkb(ana.ref_internal, 1'b1);
    chkb(ana.temp_en, 1'b1);
    apb(1, ARRS_IDX_CTRL, 8'hc0);
    finish(25);
    // start while disabled is dropped; disabling mid conversion aborts
    apb(1, ARRS_IDX_ISTAT, 8'h01);
    apb(1, ARRS_IDX_CTRL, 8'h40);
    apb(0, ARRS_IDX_CTRL, 8'h00);
    chk(rdata, 32'h0000_0000);
    apb(1, ARRS_IDX_CTRL, 8'hc0);
    apb(1, ARRS_IDX_CTRL, 8'h00);
    apb(0, ARRS_IDX_ISTAT, 8'h00);
    chk(rdata, 32'h0000_0000);
    chkb(ana.converting, 1'b0);
    apb(1, ARRS_IDX_IRS, 8'h00);
    apb(1, ARRS_IDX_CTRL, 8'hc0);
    finish(25);
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      mux = (i < 3) ? cm[i] : (r[15] ? {3'b000, r[2:0]} : mt[r[5:3]]);
      bip = (i < 3) ? cb[i] : r[6];
      r = lfsr(r);
      pos_req <= (i < 3) ? cp[i] : r[9:0];
      r = lfsr(r);
      neg_req <= (i < 3) ? cn[i] : r[9:0];
      apb(1, ARRS_IDX_CTRLB, {bip, 7'h00});
      apb(1, ARRS_IDX_IRS, {2'b00, mux});
      apb(1, ARRS_IDX_CTRL, 8'hc0);
      finish(13);
      e = exp_res(mux, bip, pos_req, neg_req);
      chkb(irq, 1'b0);
      chk({ana.gain_20x, ana.mux}, {mux[0], mux});
      apb(0, ARRS_IDX_RESL, 8'h00);
      chk(rdata, {24'h00_0000, e[7:0]});
      apb(0, ARRS_IDX_RESH, 8'h00);
      chk(rdata, {30'h0, e[9:8]});
    end
    apb(0, ARRS_IDX_ISTAT, 8'h00);
    chk(rdata, 32'h0000_0001);
    report_and_stop();
  end
endmodule
